// ---- rtl/dcti_regs.vh ----
// Purpose: timing constants for the dual channel torque inhibit block
// Assumes: 200 MHz sampling clock
// Notes: times kept in their own unit, counts derived from them
`ifndef DCTI_REGS_VH
`define DCTI_REGS_VH
// ****************************************
// clock and times
// ****************************************
`define DCTI_CLK_MHZ 200
`define DCTI_PULSE_IGNORE_MS 2
`define DCTI_RESPONSE_TYP_MS 6
`define DCTI_RESPONSE_MAX_MS 10
`define DCTI_FAULT_MIN_MS 1600
`define DCTI_FAULT_TYP_MS 2300
`define DCTI_FAULT_MAX_MS 3000
// ****************************************
// derived cycle counts
// ****************************************
`define DCTI_CYC_PER_MS (`DCTI_CLK_MHZ * 1000)
// low filter: typical response, above 2 ms least, below 10 ms most
`define DCTI_FILTER_CYC (`DCTI_RESPONSE_TYP_MS * `DCTI_CYC_PER_MS)
// disagreement limit: typical detection, between 1.6 s and 3.0 s
`define DCTI_FAULT_CYC (`DCTI_FAULT_TYP_MS * `DCTI_CYC_PER_MS)
`endif

// ---- rtl/dcti_filter.v ----
// Purpose: per-channel synchroniser and low-going glitch filter
// Assumes: raw pin input, single clock domain
// Notes: low must persist filter_cyc cycles before the output falls
`timescale 1ns/1ps
module dcti_filter #(
  parameter integer FILTER_CYC = 1200000,
  parameter integer CW = 21
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  input wire clk_en,
  // pin side
  input wire pin_in,
  // filtered level
  output reg level_high
);
  // ****************************************
  // synchroniser
  // ****************************************
  reg sync_1; // first stage, read only by sync_2
  reg sync_2; // second stage, safe to use
  reg [CW-1:0] low_count; // cycles spent low
  // two stage sync, resets to low (inhibit)
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_1 <= 1'b0;
      sync_2 <= 1'b0;
    end else if (clk_en) begin
      sync_1 <= pin_in;
      sync_2 <= sync_1;
    end
  end
  // ****************************************
  // low pulse filter
  // ****************************************
  // high passes at once, low only after the full count
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_count <= {CW{1'b0}};
      level_high <= 1'b0;
    end else if (clk_en) begin
      if (sync_2) begin
        // high: drop any pending short pulse
        low_count <= {CW{1'b0}};
        level_high <= 1'b1;
      end else if (low_count >= FILTER_CYC[CW-1:0] - 1'b1) begin
        // low long enough: channel requests inhibit
        level_high <= 1'b0;
      end else begin
        // still inside the ignore window
        low_count <= low_count + 1'b1;
      end
    end
  end
endmodule // dcti_filter

// ---- rtl/dcti_top.v ----
// Purpose: dual channel torque inhibit supervisor
// Assumes: 200 MHz clock, power-on reset drives resetn
// Notes: fault latch clears only by reset (power cycle)
`timescale 1ns/1ps
`include "dcti_regs.vh"
module dcti_top #(
  parameter integer FILTER_CYC = `DCTI_FILTER_CYC,
  parameter integer FAULT_CYC = `DCTI_FAULT_CYC,
  parameter integer FCW = 21,
  parameter integer DCW = 30
) (
  // clock, reset, enable
  input wire clk,
  input wire resetn,
  input wire clk_en,
  // inhibit pins
  input wire inhibit_input_a,
  input wire inhibit_input_b,
  // torque permission to the gate drivers
  output reg torque_enable,
  // isolated status relay
  output reg status_relay_a,
  output reg status_relay_b,
  // diagnostics
  output reg fault_latched,
  output reg channels_disagree
);
  // ****************************************
  // state encoding
  // ****************************************
  localparam [1:0] ST_SAFE = 2'h0; // both low
  localparam [1:0] ST_RUN = 2'h1; // both high
  localparam [1:0] ST_DISAGREE = 2'h2; // opposite levels
  localparam [1:0] ST_FAULT = 2'h3; // latched fault
  // ****************************************
  // signals
  // ****************************************
  wire level_a; // filtered channel a
  wire level_b; // filtered channel b
  reg [1:0] state; // supervisor state
  reg [1:0] next_state; // next supervisor state
  reg [DCW-1:0] disagree_count; // disagreement timer
  wire limit_hit; // disagreement reached the limit
  // ****************************************
  // channel filters
  // ****************************************
  dcti_filter #(.FILTER_CYC(FILTER_CYC), .CW(FCW)) u_filt_a (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .pin_in(inhibit_input_a),
    .level_high(level_a)
  );
  dcti_filter #(.FILTER_CYC(FILTER_CYC), .CW(FCW)) u_filt_b (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .pin_in(inhibit_input_b),
    .level_high(level_b)
  );
  // limit reached on the last cycle of the window
  assign limit_hit = (disagree_count >= FAULT_CYC[DCW-1:0] - 1'b1);
  // ****************************************
  // disagreement timer
  // ****************************************
  // counts while levels differ, clears on agreement, except frozen in fault state
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      disagree_count <= {DCW{1'b0}};
    end else if (clk_en) begin
      if (state == ST_FAULT) begin
        // frozen once latched
        disagree_count <= disagree_count;
      end else if (level_a ^ level_b) begin
        if (!limit_hit) begin
          disagree_count <= disagree_count + 1'b1;
        end
      end else begin
        disagree_count <= {DCW{1'b0}};
      end
    end
  end
  // ****************************************
  // next state
  // ****************************************
  // fault is absorbing; no path bypasses inhibit
  always @* begin
    next_state = state;
    case (state)
      ST_FAULT: begin
        next_state = ST_FAULT;
      end
      default: begin
        if ((level_a ^ level_b) && limit_hit) begin
          next_state = ST_FAULT;
        end else if (level_a ^ level_b) begin
          next_state = ST_DISAGREE;
        end else if (level_a && level_b) begin
          next_state = ST_RUN;
        end else begin
          next_state = ST_SAFE;
        end
      end
    endcase
  end
  // ****************************************
  // state and outputs
  // ****************************************
  // outputs registered; relay pair closed only in safe state
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_SAFE;
      torque_enable <= 1'b0;
      status_relay_a <= 1'b0;
      status_relay_b <= 1'b0;
      fault_latched <= 1'b0;
      channels_disagree <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      // torque only in run state
      torque_enable <= (next_state == ST_RUN);
      // relay pair closed only when the next state is safe
      status_relay_a <= (next_state == ST_SAFE);
      status_relay_b <= (next_state == ST_SAFE);
      fault_latched <= (next_state == ST_FAULT);
      channels_disagree <= (next_state == ST_DISAGREE);
    end
  end
endmodule // dcti_top

// ---- verification/dcti_monitor.sv ----
// Purpose: port checker for dcti_top
// Assumes: one clock, resetn async active low
// Notes: helper counter times filtered disagreement
`timescale 1ns/1ps
module dcti_monitor #(parameter integer FAULT_CYC = 40) (
  // clock, reset, inputs
  input wire clk, input wire resetn, input wire clk_en,
  input wire inhibit_input_a, input wire inhibit_input_b,
  // outputs watched
  input wire torque_enable, input wire status_relay_a, input wire status_relay_b,
  input wire fault_latched, input wire channels_disagree
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  reg [31:0] dis_cnt; // cycles of disagreement so far
  always @(posedge clk or negedge resetn) begin
    if (!resetn) dis_cnt <= 32'h0;
    else dis_cnt <= channels_disagree ? dis_cnt + 32'h1 : 32'h0;
  end
  relay_pair_a: assert property (status_relay_a == status_relay_b)
    else $error("relay outputs differ");
  run_exclusive_a: assert property (torque_enable |-> !status_relay_a && !channels_disagree
    && !fault_latched) else $error("torque with relay, disagree or fault");
  fault_hold_a: assert property (fault_latched |=> fault_latched)
    else $error("fault latch released");
  fault_safe_a: assert property (fault_latched |-> !torque_enable && !status_relay_a)
    else $error("fault without safe outputs");
  low_stops_a: assert property ((!inhibit_input_a)[*8] ##1 (!inhibit_input_a)[*6]
    |-> !torque_enable) else $error("torque kept on low input");
  stop_cause_a: assert property ($fell(torque_enable) |->
    !$past(inhibit_input_a, 5) || !$past(inhibit_input_b, 5))
    else $error("torque dropped without a held low input");
  fault_late_a: assert property (dis_cnt <= FAULT_CYC + 1)
    else $error("disagreement outlived fault limit");
  fault_early_a: assert property ($rose(fault_latched) |-> dis_cnt >= FAULT_CYC - 1)
    else $error("fault before disagreement limit");
  safe_relay_a: assert property ((!inhibit_input_a && !inhibit_input_b && !fault_latched)[*8]
    ##1 (!inhibit_input_a && !inhibit_input_b)[*6] |-> status_relay_a)
    else $error("relay off in safe state");
  run_on_a: assert property ((inhibit_input_a && inhibit_input_b && !fault_latched)[*6]
    |-> torque_enable) else $error("torque off with both inputs high");
endmodule // dcti_monitor
bind dcti_top dcti_monitor #(.FAULT_CYC(FAULT_CYC)) u_mon (.clk(clk), .resetn(resetn),
  .clk_en(clk_en), .inhibit_input_a(inhibit_input_a), .inhibit_input_b(inhibit_input_b),
  .torque_enable(torque_enable), .status_relay_a(status_relay_a),
  .status_relay_b(status_relay_b), .fault_latched(fault_latched),
  .channels_disagree(channels_disagree));

// ---- verification/dcti_ctl.sv ----
// Purpose: model of the outside safety controller
// Assumes: levels change just after a falling edge
// Notes: both channels start low, the safe request
`timescale 1ns/1ps
module dcti_ctl (
  input wire clk,
  output reg inhibit_input_a,
  output reg inhibit_input_b
);
  initial begin inhibit_input_a = 1'b0; inhibit_input_b = 1'b0; end
  // set both channel levels and hold them n cycles
  task drive(input a, input b, input integer n); begin
    @(negedge clk);
    inhibit_input_a = a;
    inhibit_input_b = b;
    repeat (n) @(posedge clk);
  end endtask
endmodule // dcti_ctl

// ---- verification/tb.sv ----
// Purpose: scenario testbench for dcti_top
// Assumes: filter 8 cycles, fault limit 40 cycles
// Notes: checks start 1 ns after the sampling edge, 1 ns apart
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg clk_en = 1'b1;
  wire ia, ib, te, sa, sb, fl, cd;
  integer n_fail = 0;
  integer n_tests = 0;
  integer cyc = 0;
  dcti_ctl u_ctl (.clk(clk), .inhibit_input_a(ia), .inhibit_input_b(ib));
  dcti_top #(.FILTER_CYC(8), .FAULT_CYC(40)) DUT (.clk(clk), .resetn(resetn),
    .clk_en(clk_en), .inhibit_input_a(ia), .inhibit_input_b(ib), .torque_enable(te),
    .status_relay_a(sa), .status_relay_b(sb), .fault_latched(fl), .channels_disagree(cd));
  initial begin forever #2.5 clk = ~clk; end
  // compare one output to its expected level
  task chk(input [63:0] nm, input e, input g); begin
    #1 n_tests = n_tests + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0s expected %b seen %b", nm, e, g);
    end
  end endtask
  task end_sim; begin
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end endtask
  task t_run; begin
    u_ctl.drive(1'b0, 1'b0, 20); chk("relay", 1'b1, sb);
    chk("torque", 1'b0, te);
    u_ctl.drive(1'b1, 1'b1, 20); chk("torque", 1'b1, te);
    chk("relay", 1'b0, sa);
    $display("run done");
  end endtask
  task t_glitch; begin
    u_ctl.drive(1'b0, 1'b1, 4); u_ctl.drive(1'b1, 1'b1, 20);
    chk("torque", 1'b1, te);
    $display("glitch done");
  end endtask
  task t_stop; begin
    u_ctl.drive(1'b0, 1'b1, 20); chk("torque", 1'b0, te);
    chk("disagree", 1'b1, cd);
    chk("relay", 1'b0, sa);
    u_ctl.drive(1'b0, 1'b0, 20); chk("relay", 1'b1, sa);
    chk("fault", 1'b0, fl);
    $display("stop done");
  end endtask
  task t_fault; begin
    u_ctl.drive(1'b1, 1'b0, 70); chk("fault", 1'b1, fl);
    u_ctl.drive(1'b1, 1'b1, 20); chk("torque", 1'b0, te);
    @(negedge clk) resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    u_ctl.drive(1'b1, 1'b1, 20); chk("torque", 1'b1, te);
    $display("fault done");
  end endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      end_sim;
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    t_run;
    t_glitch;
    t_stop;
    t_fault;
    end_sim;
  end
endmodule // tb
